// ==== common/uar_pkg.sv ====
// uar_pkg: shared constants and types of the ascii serial responder
// assumes a 100 MHz system clock and a 32-bit apb register port
package uar_pkg;

    // ------------------------------------------------------------
    // serial timing
    // ------------------------------------------------------------
    localparam int unsigned CLOCK_HZ = 100_000_000;
    localparam int unsigned BAUD_BPS = 9600;
    localparam int unsigned BIT_CYCLES = (CLOCK_HZ + BAUD_BPS / 2) / BAUD_BPS;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned BUF_DEPTH = 16;
    localparam int unsigned MSG_LEN = 4;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_DROP = 12'h008;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_RXPEND_BIT = 9;
    localparam int STAT_ERRPEND_BIT = 10;
    localparam int STAT_TXPEND_BIT = 11;
    localparam logic [15:0] DROP_RESET = 16'h0000;

    // ------------------------------------------------------------
    // characters
    // ------------------------------------------------------------
    localparam logic [7:0] CH_UPPER_T = 8'h54;
    localparam logic [7:0] CH_LOWER_T = 8'h74;
    localparam logic [7:0] CH_UPPER_O = 8'h4F;
    localparam logic [7:0] CH_UPPER_K = 8'h4B;
    localparam logic [7:0] CH_LOWER_O = 8'h6F;
    localparam logic [7:0] CH_LOWER_K = 8'h6B;
    localparam logic [7:0] CH_UPPER_U = 8'h55;
    localparam logic [7:0] CH_UPPER_C = 8'h43;
    localparam logic [7:0] CH_UPPER_P = 8'h50;
    localparam logic [7:0] CH_UPPER_E = 8'h45;
    localparam logic [7:0] CH_UPPER_F = 8'h46;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;

    // reply kind held in each buffer entry
    typedef enum logic [2:0] {
        KIND_OK = 3'b000,
        KIND_OK_LOW = 3'b001,
        KIND_UNKNOWN = 3'b010,
        KIND_PARITY = 3'b011,
        KIND_FRAMING = 3'b100,
        KIND_OVERRUN = 3'b101
    } uar_kind_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } uar_apb_req_t;

endpackage

// ==== src/uar_responder.sv ====
// uar_responder: serial responder answering each character with a reply
// assumes synchronous serial input and an apb master on the register port
//
// Notes on behaviour
// - eight data bits per character, both ways
// - data bits least significant first
// - even parity bit follows data, checked
// - 9600 bits per second from clock
// - received line used without inversion
// - replies queued in sixteen byte ring
// - 54H answered by 4FH 4BH 0DH 0AH
// - 74H answered by 6FH 6BH 0DH 0AH
// - other bytes answered by 55H 43H
// - parity error answered by 50H 45H
// - framing error answered by 46H 45H
// - overrun answered by 4FH 45H
// - three events drive the sequencing
// - receive events outrank transmit done
// - received byte queued only if room
// - error kind queued only if room
// - idle waits, sends when buffer non-empty
// - receive serviced while reply is sent
// - after last character recheck buffer
// - replies leave buffer oldest first
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module uar_responder #(
    parameter int unsigned BIT_CYCLES = uar_pkg::BIT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire uar_pkg::uar_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serialInPin,
    output logic serialOutPin
);
    import uar_pkg::*;

    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);
    localparam logic [2:0] DATA_LAST = 3'(DATA_BITS - 1);
    localparam logic [1:0] MSG_LAST = 2'(MSG_LEN - 1);
    localparam logic [4:0] BUF_FULL = 5'(BUF_DEPTH);

    typedef enum logic [2:0] {
        LN_IDLE = 3'b000,
        LN_START = 3'b001,
        LN_DATA = 3'b010,
        LN_PAR = 3'b011,
        LN_STOP = 3'b100
    } uar_line_t;

    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_SEND = 1'b1
    } uar_seq_t;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // reply byte for a kind and position
    function automatic logic [7:0] msgByte(input uar_kind_t kind, input logic [1:0] idx);
        logic [7:0] first;
        logic [7:0] second;
        first = CH_UPPER_U;
        second = CH_UPPER_C;
        case (kind)
            KIND_OK: begin
                first = CH_UPPER_O;
                second = CH_UPPER_K;
            end
            KIND_OK_LOW: begin
                first = CH_LOWER_O;
                second = CH_LOWER_K;
            end
            KIND_PARITY: begin
                first = CH_UPPER_P;
                second = CH_UPPER_E;
            end
            KIND_FRAMING: begin
                first = CH_UPPER_F;
                second = CH_UPPER_E;
            end
            KIND_OVERRUN: begin
                first = CH_UPPER_O;
                second = CH_UPPER_E;
            end
            default: begin
                first = CH_UPPER_U;
                second = CH_UPPER_C;
            end
        endcase
        case (idx)
            2'b00: msgByte = first;
            2'b01: msgByte = second;
            2'b10: msgByte = CH_CR;
            default: msgByte = CH_LF;
        endcase
    endfunction

    // reply kind chosen by a received character
    function automatic uar_kind_t charKind(input logic [7:0] ch);
        if (ch == CH_UPPER_T) begin
            charKind = KIND_OK;
        end else if (ch == CH_LOWER_T) begin
            charKind = KIND_OK_LOW;
        end else begin
            charKind = KIND_UNKNOWN;
        end
    endfunction

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rstSync_reg;
    logic rstN;

    // two flops release the asynchronous reset
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_reg <= 2'b00;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end
    assign rstN = rstSync_reg[1];

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    uar_line_t rxState_reg, rxState_next;
    logic [15:0] rxCnt_reg, rxCnt_next;
    logic [2:0] rxBit_reg, rxBit_next;
    logic [7:0] rxShift_reg, rxShift_next;
    logic rxPar_reg, rxPar_next;
    logic rxTick;
    logic rxDonePulse;
    logic rxErrPulse;
    uar_kind_t rxErrKind;

    assign rxTick = (rxCnt_reg == 16'h0000);
    // middle of stop bit decides done, framing or parity
    assign rxDonePulse = (rxState_reg == LN_STOP) && rxTick && serialInPin
        && !(^{rxShift_reg, rxPar_reg});
    assign rxErrPulse = (rxState_reg == LN_STOP) && rxTick && !rxDonePulse;
    assign rxErrKind = !serialInPin ? KIND_FRAMING : KIND_PARITY;

    // receive sequencing, sampled mid bit
    always_comb begin
        rxState_next = rxState_reg;
        rxCnt_next = rxTick ? BIT_LAST : rxCnt_reg - 16'h0001;
        rxBit_next = rxBit_reg;
        rxShift_next = rxShift_reg;
        rxPar_next = rxPar_reg;
        case (rxState_reg)
            LN_IDLE: begin
                rxCnt_next = HALF_LAST;
                if (!serialInPin) begin
                    rxState_next = LN_START;
                end
            end
            LN_START: begin
                if (rxTick) begin
                    rxBit_next = 3'b000;
                    rxState_next = serialInPin ? LN_IDLE : LN_DATA;
                end
            end
            LN_DATA: begin
                if (rxTick) begin
                    rxShift_next = {serialInPin, rxShift_reg[7:1]};
                    rxBit_next = rxBit_reg + 3'b001;
                    if (rxBit_reg == DATA_LAST) begin
                        rxState_next = LN_PAR;
                    end
                end
            end
            LN_PAR: begin
                if (rxTick) begin
                    rxPar_next = serialInPin;
                    rxState_next = LN_STOP;
                end
            end
            LN_STOP: begin
                if (rxTick) begin
                    rxState_next = LN_IDLE;
                end
            end
            default: rxState_next = LN_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            rxState_reg <= LN_IDLE;
            rxCnt_reg <= 16'h0000;
            rxBit_reg <= 3'b000;
            rxShift_reg <= 8'h00;
            rxPar_reg <= 1'b0;
        end else begin
            rxState_reg <= rxState_next;
            rxCnt_reg <= rxCnt_next;
            rxBit_reg <= rxBit_next;
            rxShift_reg <= rxShift_next;
            rxPar_reg <= rxPar_next;
        end
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    uar_line_t txState_reg, txState_next;
    logic [15:0] txCnt_reg, txCnt_next;
    logic [2:0] txBit_reg, txBit_next;
    logic [7:0] txShift_reg, txShift_next;
    logic txPar_reg, txPar_next;
    logic txOut_reg, txOut_next;
    logic txTick;
    logic txGo;
    logic [7:0] txByte;
    logic txDonePulse;

    assign txTick = (txCnt_reg == 16'h0000);
    assign txDonePulse = (txState_reg == LN_STOP) && txTick;

    // frame shifter, one bit per bit time
    always_comb begin
        txState_next = txState_reg;
        txCnt_next = txTick ? BIT_LAST : txCnt_reg - 16'h0001;
        txBit_next = txBit_reg;
        txShift_next = txShift_reg;
        txPar_next = txPar_reg;
        txOut_next = txOut_reg;
        case (txState_reg)
            LN_IDLE: begin
                txOut_next = 1'b1;
                txCnt_next = BIT_LAST;
                if (txGo) begin
                    txOut_next = 1'b0;
                    txShift_next = txByte;
                    txPar_next = ^txByte;
                    txBit_next = 3'b000;
                    txState_next = LN_START;
                end
            end
            LN_START: begin
                if (txTick) begin
                    txOut_next = txShift_reg[0];
                    txShift_next = {1'b0, txShift_reg[7:1]};
                    txState_next = LN_DATA;
                end
            end
            LN_DATA: begin
                if (txTick) begin
                    txBit_next = txBit_reg + 3'b001;
                    if (txBit_reg == DATA_LAST) begin
                        txOut_next = txPar_reg;
                        txState_next = LN_PAR;
                    end else begin
                        txOut_next = txShift_reg[0];
                        txShift_next = {1'b0, txShift_reg[7:1]};
                    end
                end
            end
            LN_PAR: begin
                if (txTick) begin
                    txOut_next = 1'b1;
                    txState_next = LN_STOP;
                end
            end
            LN_STOP: begin
                if (txTick) begin
                    txState_next = LN_IDLE;
                end
            end
            default: txState_next = LN_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            txState_reg <= LN_IDLE;
            txCnt_reg <= 16'h0000;
            txBit_reg <= 3'b000;
            txShift_reg <= 8'h00;
            txPar_reg <= 1'b0;
            txOut_reg <= 1'b1;
        end else begin
            txState_reg <= txState_next;
            txCnt_reg <= txCnt_next;
            txBit_reg <= txBit_next;
            txShift_reg <= txShift_next;
            txPar_reg <= txPar_next;
            txOut_reg <= txOut_next;
        end
    end
    assign serialOutPin = txOut_reg;

    // ------------------------------------------------------------
    // events and their service
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic enable;
    logic rxPend_reg, errPend_reg, txPend_reg;
    logic [7:0] rxData_reg;
    uar_kind_t errKind_reg;
    logic svcRx, svcErr, svcTx;
    logic overrunHit;
    logic bufFull, bufEmpty;
    logic push, pop, dropHit;
    uar_kind_t pushKind;
    uar_seq_t seqState_reg;

    assign enable = ctrl_reg[CTRL_ENABLE_BIT];
    // receive events first, transmit done lowest, one per cycle
    assign svcRx = enable && rxPend_reg;
    assign svcErr = enable && errPend_reg && !rxPend_reg;
    assign svcTx = enable && txPend_reg && !rxPend_reg && !errPend_reg
        && (seqState_reg == SEQ_SEND);
    // new character while the previous one is still unserviced
    assign overrunHit = rxDonePulse && rxPend_reg && !svcRx;
    assign pushKind = svcRx ? charKind(rxData_reg) : errKind_reg;
    assign push = (svcRx || svcErr) && !bufFull;
    assign dropHit = (svcRx || svcErr) && bufFull;

    // flags: a new event wins over the clear of the same cycle
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            rxPend_reg <= 1'b0;
            errPend_reg <= 1'b0;
            txPend_reg <= 1'b0;
            rxData_reg <= 8'h00;
            errKind_reg <= KIND_UNKNOWN;
        end else begin
            rxPend_reg <= (rxPend_reg && !svcRx) || rxDonePulse;
            errPend_reg <= (errPend_reg && !svcErr) || rxErrPulse || overrunHit;
            txPend_reg <= (txPend_reg && !svcTx) || txDonePulse;
            if (rxDonePulse) begin
                rxData_reg <= rxShift_reg;
            end
            if (overrunHit) begin
                errKind_reg <= KIND_OVERRUN;
            end else if (rxErrPulse) begin
                errKind_reg <= rxErrKind;
            end
        end
    end

    // ------------------------------------------------------------
    // reply ring buffer
    // ------------------------------------------------------------
    logic [7:0] ring [BUF_DEPTH];
    logic [3:0] wrPtr_reg, rdPtr_reg;
    logic [4:0] count_reg;
    uar_kind_t headKind;

    assign bufFull = (count_reg == BUF_FULL);
    assign bufEmpty = (count_reg == 5'h00);
    assign headKind = uar_kind_t'(ring[rdPtr_reg][2:0]);

    // storage has no reset; only written entries are ever read
    always_ff @(posedge clock) begin
        if (push) begin
            ring[wrPtr_reg] <= {5'h00, pushKind};
        end
    end

    // pointers wrap at sixteen, oldest entry leaves first
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            wrPtr_reg <= 4'h0;
            rdPtr_reg <= 4'h0;
            count_reg <= 5'h00;
        end else begin
            wrPtr_reg <= wrPtr_reg + {3'b000, push};
            rdPtr_reg <= rdPtr_reg + {3'b000, pop};
            count_reg <= count_reg + {4'h0, push} - {4'h0, pop};
        end
    end

    // ------------------------------------------------------------
    // reply sequencer
    // ------------------------------------------------------------
    uar_kind_t kind_reg;
    logic [1:0] idx_reg;
    logic lastChar;

    assign pop = enable && (seqState_reg == SEQ_IDLE) && !bufEmpty;
    assign lastChar = (idx_reg == MSG_LAST);
    // first byte on pop, later bytes on each transmit done
    assign txGo = pop || (svcTx && !lastChar);
    assign txByte = pop ? msgByte(headKind, 2'b00) : msgByte(kind_reg, idx_reg + 2'b01);

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            seqState_reg <= SEQ_IDLE;
            kind_reg <= KIND_UNKNOWN;
            idx_reg <= 2'b00;
        end else begin
            case (seqState_reg)
                SEQ_IDLE: begin
                    if (pop) begin
                        kind_reg <= headKind;
                        idx_reg <= 2'b00;
                        seqState_reg <= SEQ_SEND;
                    end
                end
                SEQ_SEND: begin
                    if (svcTx) begin
                        idx_reg <= idx_reg + 2'b01;
                        if (lastChar) begin
                            seqState_reg <= SEQ_IDLE;
                        end
                    end
                end
                default: seqState_reg <= SEQ_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    logic [15:0] drop_reg;
    logic [31:0] prdata_reg;
    logic [31:0] statusWord;
    logic [31:0] readWord;
    logic setup, access, hitCtrl, hitStatus, hitDrop, hitAny;

    assign setup = apbReq.psel && !apbReq.penable;
    assign access = apbReq.psel && apbReq.penable;
    assign hitCtrl = (apbReq.paddr == ADDR_CTRL);
    assign hitStatus = (apbReq.paddr == ADDR_STATUS);
    assign hitDrop = (apbReq.paddr == ADDR_DROP);
    assign hitAny = hitCtrl || hitStatus || hitDrop;

    // live state as seen by software
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[STAT_COUNT_LSB +: 5] = count_reg;
        statusWord[STAT_BUSY_BIT] = (seqState_reg == SEQ_SEND);
        statusWord[STAT_RXPEND_BIT] = rxPend_reg;
        statusWord[STAT_ERRPEND_BIT] = errPend_reg;
        statusWord[STAT_TXPEND_BIT] = txPend_reg;
    end

    assign readWord = hitCtrl ? ctrl_reg
        : hitStatus ? statusWord
        : hitDrop ? {16'h0000, drop_reg}
        : 32'h0000_0000;

    // read data caught in setup, control written in access
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            ctrl_reg <= CTRL_RESET;
            drop_reg <= DROP_RESET;
            prdata_reg <= 32'h0000_0000;
        end else begin
            if (setup) begin
                prdata_reg <= readWord;
            end
            if (access && apbReq.pwrite && hitCtrl) begin
                ctrl_reg <= {31'h0000_0000, apbReq.pwdata[CTRL_ENABLE_BIT]};
            end
            if (dropHit && (drop_reg != 16'hFFFF)) begin
                drop_reg <= drop_reg + 16'h0001;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = access && !hitAny;

endmodule

// ==== bench/uar_serial_partner.sv ====
// uar_serial_partner: remote serial party sending and collecting characters
// assumes the responder's frame format and BIT_CYCLES clocks per bit
`timescale 1ns/1ps
module uar_serial_partner #(
    parameter int unsigned BIT_CYCLES = 16
) (
    input wire logic clock,
    output logic lineToDut,
    input wire logic lineFromDut
);
    logic [7:0] gotQ[$];
    int lineBad = 0;
    initial lineToDut = 1'b1;
    // send one frame, optionally with wrong parity or a low stop bit
    task automatic send_char(input logic [7:0] d, input logic badPar, input logic lowStop);
        logic [11:0] frame;
        frame = {1'b1, ~lowStop, ^d ^ badPar, d, 1'b0};
        @(posedge clock);
        for (int i = 0; i < (lowStop ? 12 : 11); i++) begin
            lineToDut <= frame[i];
            repeat (BIT_CYCLES) @(posedge clock);
        end
        lineToDut <= 1'b1;
    endtask
    // collect replies at mid-bit, counting bad parity or stop
    initial begin
        logic [9:0] sh;
        forever begin
            @(negedge lineFromDut);
            repeat (BIT_CYCLES / 2) @(posedge clock);
            for (int i = 0; i < 10; i++) begin
                repeat (BIT_CYCLES) @(posedge clock);
                sh[i] = lineFromDut;
            end
            if (^sh[8:0] !== 1'b0 || sh[9] !== 1'b1) lineBad++;
            gotQ.push_back(sh[7:0]);
        end
    end
endmodule

// ==== bench/uar_responder_monitor.sv ====
// uar_responder_monitor: port assertions for the serial responder
// assumes binding onto uar_responder with BIT_CYCLES of at least 16
`timescale 1ns/1ps
module uar_responder_monitor #(
    parameter int unsigned BIT_CYCLES = 16
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire uar_pkg::uar_apb_req_t apbReq,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serialInPin,
    input wire logic serialOutPin
);
    import uar_pkg::*;
    // ------------------------------------------------------------
    // frame trackers
    // ------------------------------------------------------------
    localparam int BITN = BIT_CYCLES;
    localparam int STOP_MID = 10 * BITN + BITN / 2;
    int txCnt;
    int rxCnt;
    logic txPar;
    logic txPrev;
    logic rxPrev;
    logic enReg;
    wire access = apbReq.psel && apbReq.penable;
    wire mapped = apbReq.paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_DROP};
    wire txMid = txCnt > BITN && txCnt < 10 * BITN && txCnt % BITN == BITN / 2;
    wire txGo = txCnt != 0 || (txPrev && !serialOutPin);
    wire rxGo = rxCnt != 0 || (rxPrev && !serialInPin);
    // sample index inside each frame, parity of sent bits, enable copy
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            txCnt <= 0;
            rxCnt <= 0;
            txPar <= 1'b0;
            txPrev <= 1'b1;
            rxPrev <= 1'b1;
            enReg <= 1'b1;
        end else begin
            txPrev <= serialOutPin;
            rxPrev <= serialInPin;
            txCnt <= (txCnt == STOP_MID || !txGo) ? 0 : txCnt + 1;
            rxCnt <= (rxCnt == STOP_MID || !rxGo) ? 0 : rxCnt + 1;
            txPar <= (txCnt == 0) ? 1'b0 : txPar ^ (txMid & serialOutPin);
            if (access && apbReq.pwrite && apbReq.paddr == ADDR_CTRL) enReg <= apbReq.pwdata[0];
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence sAccess; access; endsequence
    sequence sRxDone; rxCnt == STOP_MID && txCnt == 0 && serialOutPin && enReg; endsequence
    a_start_low: assert property (txCnt == BITN / 2 |-> !serialOutPin)
        else $error("start bit not low");
    a_stop_high: assert property (txCnt == STOP_MID |-> serialOutPin)
        else $error("stop bit not high");
    a_even_parity: assert property (txCnt == STOP_MID |-> !txPar)
        else $error("odd parity sent");
    a_bit_hold: assert property (txCnt % BITN != 0 |-> $stable(serialOutPin))
        else $error("bit changed inside bit time");
    a_reset_idle: assert property (disable iff (1'b0) !rst_b ##1 !rst_b |-> serialOutPin)
        else $error("line not idle in reset");
    a_reply_start: assert property (sRxDone |-> ##[1:20] !serialOutPin)
        else $error("no reply after character");
    a_ready_always: assert property (pready)
        else $error("pready low");
    a_unmapped_err: assert property (sAccess ##0 !mapped |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (sAccess ##0 mapped |-> !pslverr)
        else $error("mapped access refused");
endmodule

bind uar_responder uar_responder_monitor #(.BIT_CYCLES(BIT_CYCLES)) mon (
    .clock(clock), .rst_b(rst_b), .apbReq(apbReq), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialInPin(serialInPin), .serialOutPin(serialOutPin)
);

// ==== bench/tb_uar_responder.sv ====
// tb_uar_responder: apb and serial tests of the responder
// assumes uar_serial_partner on the line and the bound monitor
`timescale 1ns/1ps
module tb_uar_responder;
    import uar_pkg::*;
    `define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
        $display("BAD %0t got %h exp %h", $time, g, e); end end
    localparam int unsigned BITC = 16;
    localparam logic [31:0] MSG_OK = {CH_UPPER_O, CH_UPPER_K, CH_CR, CH_LF};
    localparam logic [31:0] MSG_OK2 = {CH_LOWER_O, CH_LOWER_K, CH_CR, CH_LF};
    localparam logic [31:0] MSG_UC = {CH_UPPER_U, CH_UPPER_C, CH_CR, CH_LF};
    localparam logic [31:0] MSG_PE = {CH_UPPER_P, CH_UPPER_E, CH_CR, CH_LF};
    localparam logic [31:0] MSG_FE = {CH_UPPER_F, CH_UPPER_E, CH_CR, CH_LF};
    localparam logic [31:0] MSG_OE = {CH_UPPER_O, CH_UPPER_E, CH_CR, CH_LF};
    logic clock;
    logic rst_b;
    uar_apb_req_t apbReq;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic serialInPin;
    logic serialOutPin;
    logic [31:0] rd;
    logic err;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    uar_responder #(.BIT_CYCLES(BITC)) dut (
        .clock(clock), .rst_b(rst_b), .apbReq(apbReq), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serialInPin(serialInPin), .serialOutPin(serialOutPin)
    );
    uar_serial_partner #(.BIT_CYCLES(BITC)) peer (
        .clock(clock), .lineToDut(serialInPin), .lineFromDut(serialOutPin)
    );
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge clock);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge clock);
        apbReq.penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apbReq <= '0;
    endtask
    task automatic expect_reply(input logic [31:0] msg);
        logic [7:0] b;
        while (peer.gotQ.size() < 4) @(posedge clock);
        for (int i = 3; i >= 0; i--) begin
            b = peer.gotQ.pop_front();
            `CHECK(b, msg[8*i +: 8])
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            $display("BAD %0t timeout", $time);
            final_report();
        end
    end
    initial begin
        rst_b = 1'b0;
        apbReq = '0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        // register defaults and unmapped access
        apb(1'b0, ADDR_CTRL, 32'h0000_0000); `CHECK(rd, CTRL_RESET)
        apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000); `CHECK(rd, 32'h0000_0000)
        apb(1'b0, 12'h00C, 32'h0000_0000); `CHECK({err, rd}, 33'h1_0000_0000)
        // every reply kind but overrun, sent back to back
        peer.send_char(CH_UPPER_T, 1'b0, 1'b0);
        peer.send_char(CH_LOWER_T, 1'b0, 1'b0);
        peer.send_char(8'hFF, 1'b0, 1'b0);
        peer.send_char(8'h00, 1'b1, 1'b0);
        peer.send_char(8'h5A, 1'b0, 1'b1);
        expect_reply(MSG_OK);
        expect_reply(MSG_OK2);
        expect_reply(MSG_UC);
        expect_reply(MSG_PE);
        expect_reply(MSG_FE);
        repeat (BITC) @(posedge clock);
        // overrun while servicing is held off
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        peer.send_char(CH_UPPER_T, 1'b0, 1'b0);
        peer.send_char(CH_LOWER_T, 1'b0, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000); `CHECK(rd, 32'h0000_0600)
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        expect_reply(MSG_OK2);
        expect_reply(MSG_OE);
        // fill the ring until it refuses, then drain it
        repeat (23) peer.send_char(8'h5A, 1'b0, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000); `CHECK(rd[8:0], 9'h110)
        peer.send_char(8'h5A, 1'b0, 1'b0);
        repeat (22) expect_reply(MSG_UC);
        apb(1'b0, ADDR_DROP, 32'h0000_0000); `CHECK(rd, 32'h0000_0002)
        repeat (4 * BITC) @(posedge clock);
        `CHECK(peer.gotQ.size(), 0)
        `CHECK(peer.lineBad, 0)
        final_report();
    end
endmodule
